// File: src/smci_map.vh
// constants of the serial mode command interpreter
`ifndef SMCI_MAP_VH
`define SMCI_MAP_VH

// timebase
`define SMCI_MS_NS 1000000
`define SMCI_CLK_NS 100
`define SMCI_WIN_MS 16'h03e8
`define SMCI_BREAK_MS 16'h1770

// buffer geometry
`define SMCI_DEPTH 7'h64
`define SMCI_AW 7

// serial modes
`define SMCI_MODE_PASS 2'h0
`define SMCI_MODE_MAX 2'h2
`define SMCI_BAUD_9600 3'h3

// parameter reset values
`define SMCI_DEF_MODE 2'h0
`define SMCI_DEF_RO 8'h03
`define SMCI_DEF_GT 16'h03e8
`define SMCI_DEF_CC 8'h2b
`define SMCI_DEF_CT 16'h2710
`define SMCI_DEF_BD 3'h3

// characters
`define SMCI_CH_A 8'h41
`define SMCI_CH_T 8'h54
`define SMCI_CH_CR 8'h0d
`define SMCI_CH_COMMA 8'h2c
`define SMCI_CH_LX 8'h78
`define SMCI_CH_UX 8'h58
`define SMCI_CH_O 8'h4f
`define SMCI_CH_K 8'h4b
`define SMCI_CH_E 8'h45
`define SMCI_CH_R 8'h52

// two-letter command codes
`define SMCI_CMD_MODE 16'h4150
`define SMCI_CMD_PKTO 16'h524f
`define SMCI_CMD_GUARD 16'h4754
`define SMCI_CMD_ESC 16'h4343
`define SMCI_CMD_CMTO 16'h4354
`define SMCI_CMD_BAUD 16'h4244
`define SMCI_CMD_EXIT 16'h434e
`define SMCI_CMD_APPLY 16'h4143
`define SMCI_CMD_WRITE 16'h5752
`define SMCI_CMD_RESTORE 16'h5245

// reply kinds
`define SMCI_RSP_OK 2'h0
`define SMCI_RSP_ERR 2'h1
`define SMCI_RSP_HEX 2'h2

`endif

// File: src/smci_tick.v
// millisecond tick divider
`timescale 1ns/1ns
`default_nettype none
module smci_tick #(
  parameter TICK_CYCLES = 10000
) (
  input wire ref_clk_i,
  input wire reset_i,
  output reg tick_o
);
  // the divider counts in 16 bits; longer ticks are not supported
  localparam [31:0] LAST_W = TICK_CYCLES - 1;
  reg [15:0] cnt;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt == LAST_W[15:0]) begin
      cnt <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: src/smci_mem.v
// serial input buffer storage, registered read
`timescale 1ns/1ns
`default_nettype none
`include "smci_map.vh"
module smci_mem (
  input wire ref_clk_i,
  input wire wr_en_i,
  input wire [`SMCI_AW-1:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  input wire [`SMCI_AW-1:0] rd_addr_i,
  output reg [7:0] rd_data_o
);
  reg [7:0] mem [0:`SMCI_DEPTH-1];

  always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

// File: src/smci_top.v
// serial mode command interpreter: pass-through buffering and command mode
`timescale 1ns/1ns
`default_nettype none
`include "smci_map.vh"
module smci_top #(
  parameter TICK_CYCLES = `SMCI_MS_NS / `SMCI_CLK_NS
) (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_i,
  // host serial bytes in
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  output wire rx_ready_o,
  input wire break_i,
  input wire spi_mode_i,
  // host serial bytes out
  output reg [7:0] tx_data_o,
  output reg tx_valid_o,
  input wire tx_ready_i,
  // radio transmit payload
  output wire [7:0] rf_data_o,
  output wire rf_valid_o,
  output wire rf_last_o,
  input wire rf_ready_i,
  // radio receive payload
  input wire [7:0] rf_rx_data_i,
  input wire rf_rx_valid_i,
  output wire rf_rx_ready_o,
  // framed mode byte stream
  output reg [7:0] frame_data_o,
  output reg frame_valid_o,
  input wire frame_ready_i,
  // status and active configuration
  output reg cmd_mode_o,
  output wire [1:0] serial_mode_o,
  output wire [2:0] baud_rate_o,
  output reg nv_write_o,
  output wire idle_o
);
  localparam P_A = 3'h0, P_T = 3'h1, P_ID1 = 3'h2, P_ID2 = 3'h3, P_PAR = 3'h4, P_RSP = 3'h5;
  localparam F_IDLE = 2'h0, F_RD = 2'h1, F_TX = 2'h2;

  function [4:0] hex_nib;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39) hex_nib = {1'b1, c[3:0]};
      else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
        hex_nib = {1'b1, c[3:0] + 4'h9};
      else hex_nib = 5'h00;
    end
  endfunction

  function [7:0] nib_char;
    input [3:0] n;
    begin
      nib_char = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
    end
  endfunction

  // reply character and last flag for a given position
  function [8:0] rsp_char;
    input [1:0] kind;
    input [2:0] idx;
    input [15:0] v;
    begin
      rsp_char = {1'b1, `SMCI_CH_CR};
      case (kind)
        `SMCI_RSP_OK: begin
          if (idx == 3'h0) rsp_char = {1'b0, `SMCI_CH_O};
          else if (idx == 3'h1) rsp_char = {1'b0, `SMCI_CH_K};
        end
        `SMCI_RSP_ERR: begin
          if (idx == 3'h0) rsp_char = {1'b0, `SMCI_CH_E};
          else if (idx == 3'h1 || idx == 3'h2 || idx == 3'h4) rsp_char = {1'b0, `SMCI_CH_R};
          else if (idx == 3'h3) rsp_char = {1'b0, `SMCI_CH_O};
        end
        default: begin
          if (idx < 3'h4) rsp_char = {1'b0, nib_char(v[15 - 4 * idx -: 4])};
        end
      endcase
    end
  endfunction

  // ==========================================================================
  // configuration, active and pending
  // ==========================================================================
  reg [1:0] a_mode, p_mode;
  reg [7:0] a_ro, p_ro, a_cc, p_cc;
  reg [15:0] a_gt, p_gt, a_ct, p_ct;
  reg [2:0] a_bd, p_bd;
  reg forced_baud;

  // host on SPI has no pass-through
  wire pass = (a_mode == `SMCI_MODE_PASS) && !spi_mode_i;
  assign serial_mode_o = (spi_mode_i && a_mode == `SMCI_MODE_PASS) ? `SMCI_MODE_MAX : a_mode;
  assign baud_rate_o = forced_baud ? `SMCI_BAUD_9600 : a_bd;

  // ==========================================================================
  // millisecond timers
  // ==========================================================================
  wire tick;
  smci_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .tick_o(tick)
  );

  reg [2:0] pst;
  reg [1:0] fst;
  reg [`SMCI_AW-1:0] wr_cnt, rd_ptr;
  reg flush_req;
  reg [15:0] silent_ms, esc_ms, brk_ms;
  reg [1:0] esc_cnt;
  reg boot_pend;

  wire rx_take = rx_valid_i && rx_ready_o;
  wire buf_ok = (fst == F_IDLE) && (wr_cnt < `SMCI_DEPTH);
  // stall the host while replying or while the buffer is full or flushing
  assign rx_ready_o = (fst == F_IDLE) &&
                      (cmd_mode_o ? (pst != P_RSP) : pass ? buf_ok : !frame_valid_o);

  wire enter_esc = !cmd_mode_o && !spi_mode_i && esc_cnt == 2'h3 && silent_ms >= a_gt &&
                   fst == F_IDLE;
  wire enter_brk = !cmd_mode_o && (brk_ms >= `SMCI_BREAK_MS || (boot_pend && break_i));
  wire exit_to = cmd_mode_o && pst != P_RSP && silent_ms >= a_ct;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      silent_ms <= 16'h0000;
      esc_ms <= 16'h0000;
      esc_cnt <= 2'h0;
      brk_ms <= 16'h0000;
      boot_pend <= 1'b1;
    end else begin
      boot_pend <= 1'b0;
      if (rx_take || enter_esc || enter_brk) begin
        silent_ms <= 16'h0000;
      end else if (tick && silent_ms != 16'hffff) begin
        silent_ms <= silent_ms + 16'h0001;
      end
      if (!break_i || cmd_mode_o) begin
        brk_ms <= 16'h0000;
      end else if (tick && brk_ms != 16'hffff) begin
        brk_ms <= brk_ms + 16'h0001;
      end
      if (tick && esc_ms != 16'hffff) begin
        esc_ms <= esc_ms + 16'h0001;
      end
      // escape chars: first after guard silence, rest inside the window
      if (cmd_mode_o || spi_mode_i || enter_esc) begin
        esc_cnt <= 2'h0;
      end else if (rx_take) begin
        if (rx_data_i == a_cc && esc_cnt != 2'h3 &&
            (esc_cnt == 2'h0 ? silent_ms >= a_gt : esc_ms < `SMCI_WIN_MS)) begin
          esc_cnt <= esc_cnt + 2'h1;
          if (esc_cnt == 2'h0) esc_ms <= 16'h0000;
        end else begin
          esc_cnt <= 2'h0;
        end
      end else if (esc_cnt != 2'h3 && esc_cnt != 2'h0 && esc_ms >= `SMCI_WIN_MS) begin
        esc_cnt <= 2'h0;
      end
    end
  end

  // ==========================================================================
  // pass-through buffer and radio flush
  // ==========================================================================
  wire buf_we = rx_take && pass && !cmd_mode_o;
  smci_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(buf_we),
    .wr_addr_i(wr_cnt),
    .wr_data_i(rx_data_i),
    .rd_addr_i(rd_ptr),
    .rd_data_o(rf_data_o)
  );

  assign rf_valid_o = (fst == F_TX);
  assign rf_last_o = rf_valid_o && (rd_ptr == wr_cnt - 7'h01);
  wire [`SMCI_AW-1:0] kept = wr_cnt - {5'h00, esc_cnt};

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      fst <= F_IDLE;
      wr_cnt <= 7'h00;
      rd_ptr <= 7'h00;
      flush_req <= 1'b0;
    end else begin
      if (buf_we) begin
        wr_cnt <= wr_cnt + 7'h01;
      end
      if (enter_esc) begin
        // escape characters sit at the tail; trim them and send the rest
        wr_cnt <= kept;
        if (kept != 7'h00) flush_req <= 1'b1;
      end else if (wr_cnt == `SMCI_DEPTH) begin
        flush_req <= 1'b1;
      end else if (pass && wr_cnt != 7'h00 && esc_cnt == 2'h0 &&
                   silent_ms >= {8'h00, a_ro}) begin
        flush_req <= 1'b1;
      end
      case (fst)
        F_IDLE: begin
          // radio busy keeps the bytes buffered
          // a half-seen escape waits too, so its characters are sent only if it is abandoned
          if (flush_req && rf_ready_i && wr_cnt != 7'h00 && esc_cnt == 2'h0) begin
            fst <= F_RD;
            rd_ptr <= 7'h00;
          end
        end
        F_RD: fst <= F_TX;
        F_TX: begin
          if (rf_ready_i) begin
            if (rf_last_o) begin
              fst <= F_IDLE;
              wr_cnt <= 7'h00;
              flush_req <= 1'b0;
            end else begin
              rd_ptr <= rd_ptr + 7'h01;
              fst <= F_RD;
            end
          end
        end
        default: fst <= F_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // command parser and replies
  // ==========================================================================
  reg [15:0] cid, val, rd_val;
  reg [2:0] ndig, ridx;
  reg [1:0] rkind;
  reg err, exit_after, line_end, is_par, in_range;
  wire [4:0] nib = hex_nib(rx_data_i);
  wire [8:0] rch = rsp_char(rkind, ridx, rd_val);
  wire tx_free = !tx_valid_o || tx_ready_i;
  wire term = rx_data_i == `SMCI_CH_CR || rx_data_i == `SMCI_CH_COMMA;

  assign rf_rx_ready_o = pass && !cmd_mode_o && tx_free;
  assign idle_o = !cmd_mode_o && fst == F_IDLE && wr_cnt == 7'h00 && !tx_valid_o;

  // stored value and range check of the addressed parameter
  always @* begin
    is_par = 1'b1;
    in_range = 1'b1;
    case (cid)
      `SMCI_CMD_MODE: begin
        rd_val = {14'h0000, p_mode};
        in_range = val <= {14'h0000, `SMCI_MODE_MAX};
      end
      `SMCI_CMD_PKTO: begin
        rd_val = {8'h00, p_ro};
        in_range = val[15:8] == 8'h00;
      end
      `SMCI_CMD_GUARD: rd_val = p_gt;
      `SMCI_CMD_ESC: begin
        rd_val = {8'h00, p_cc};
        in_range = val[15:8] == 8'h00;
      end
      `SMCI_CMD_CMTO: rd_val = p_ct;
      `SMCI_CMD_BAUD: begin
        rd_val = {13'h0000, p_bd};
        in_range = val[15:3] == 13'h0000;
      end
      default: begin
        rd_val = val;
        is_par = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      a_mode <= `SMCI_DEF_MODE;
      p_mode <= `SMCI_DEF_MODE;
      a_ro <= `SMCI_DEF_RO;
      p_ro <= `SMCI_DEF_RO;
      a_gt <= `SMCI_DEF_GT;
      p_gt <= `SMCI_DEF_GT;
      a_cc <= `SMCI_DEF_CC;
      p_cc <= `SMCI_DEF_CC;
      a_ct <= `SMCI_DEF_CT;
      p_ct <= `SMCI_DEF_CT;
      a_bd <= `SMCI_DEF_BD;
      p_bd <= `SMCI_DEF_BD;
      forced_baud <= 1'b0;
      cmd_mode_o <= 1'b0;
      pst <= P_A;
      cid <= 16'h0000;
      val <= 16'h0000;
      ndig <= 3'h0;
      ridx <= 3'h0;
      rkind <= `SMCI_RSP_OK;
      err <= 1'b0;
      exit_after <= 1'b0;
      line_end <= 1'b0;
      nv_write_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
      frame_data_o <= 8'h00;
      frame_valid_o <= 1'b0;
    end else begin
      nv_write_o <= 1'b0;
      if (tx_ready_i) tx_valid_o <= 1'b0;
      if (frame_ready_i) frame_valid_o <= 1'b0;
      if (rx_take && !pass && !cmd_mode_o) begin
        frame_data_o <= rx_data_i;
        frame_valid_o <= 1'b1;
      end
      if (rf_rx_valid_i && rf_rx_ready_o) begin
        tx_data_o <= rf_rx_data_i;
        tx_valid_o <= 1'b1;
      end
      if (enter_esc || enter_brk) begin
        cmd_mode_o <= 1'b1;
        forced_baud <= enter_brk;
        pst <= P_RSP;
        rkind <= `SMCI_RSP_OK;
        ridx <= 3'h0;
        exit_after <= 1'b0;
        line_end <= 1'b1;
      end else if (exit_to) begin
        cmd_mode_o <= 1'b0;
        forced_baud <= 1'b0;
        pst <= P_A;
      end else if (cmd_mode_o && pst == P_RSP) begin
        if (tx_free) begin
          tx_data_o <= rch[7:0];
          tx_valid_o <= 1'b1;
          ridx <= ridx + 3'h1;
          if (rch[8]) begin
            pst <= line_end ? P_A : P_ID1;
            if (exit_after) begin
              cmd_mode_o <= 1'b0;
              forced_baud <= 1'b0;
            end
          end
        end
      end else if (cmd_mode_o && rx_take) begin
        case (pst)
          P_A: if (rx_data_i == `SMCI_CH_A) pst <= P_T;
          P_T: pst <= (rx_data_i == `SMCI_CH_T) ? P_ID1 : P_A;
          P_ID1, P_ID2: begin
            val <= 16'h0000;
            ndig <= 3'h0;
            err <= 1'b0;
            cid <= {cid[7:0], rx_data_i};
            pst <= (pst == P_ID1) ? P_ID2 : P_PAR;
            if (term) begin
              rkind <= `SMCI_RSP_ERR;
              ridx <= 3'h0;
              exit_after <= 1'b0;
              line_end <= rx_data_i == `SMCI_CH_CR;
              pst <= P_RSP;
            end
          end
          P_PAR: begin
            if (term) begin
              pst <= P_RSP;
              ridx <= 3'h0;
              line_end <= rx_data_i == `SMCI_CH_CR;
              exit_after <= 1'b0;
              rkind <= `SMCI_RSP_OK;
              if (err || (is_par && ndig != 3'h0 && !in_range)) begin
                rkind <= `SMCI_RSP_ERR;
              end else if (is_par && ndig == 3'h0) begin
                rkind <= `SMCI_RSP_HEX;
              end else begin
                case (cid)
                  `SMCI_CMD_MODE: p_mode <= val[1:0];
                  `SMCI_CMD_PKTO: p_ro <= val[7:0];
                  `SMCI_CMD_GUARD: p_gt <= val;
                  `SMCI_CMD_ESC: p_cc <= val[7:0];
                  `SMCI_CMD_CMTO: p_ct <= val;
                  `SMCI_CMD_BAUD: p_bd <= val[2:0];
                  `SMCI_CMD_EXIT: exit_after <= rx_data_i == `SMCI_CH_CR;
                  `SMCI_CMD_APPLY: a_mode <= p_mode;
                  `SMCI_CMD_WRITE: nv_write_o <= 1'b1;
                  `SMCI_CMD_RESTORE: begin
                    p_mode <= `SMCI_DEF_MODE;
                    p_ro <= `SMCI_DEF_RO;
                    p_gt <= `SMCI_DEF_GT;
                    p_cc <= `SMCI_DEF_CC;
                    p_ct <= `SMCI_DEF_CT;
                    p_bd <= `SMCI_DEF_BD;
                  end
                  default: rkind <= `SMCI_RSP_ERR;
                endcase
              end
            end else if ((rx_data_i == `SMCI_CH_LX || rx_data_i == `SMCI_CH_UX) &&
                         ndig == 3'h1 && val == 16'h0000) begin
              ndig <= 3'h0;
            end else if (nib[4] && ndig < 3'h4) begin
              val <= {val[11:0], nib[3:0]};
              ndig <= ndig + 3'h1;
            end else begin
              err <= 1'b1;
            end
          end
          default: pst <= P_A;
        endcase
      end
      // apply on apply, write or any exit from command mode
      if (exit_to || (pst == P_RSP && tx_free && rch[8] && exit_after) ||
          (pst == P_PAR && rx_take && term && !err &&
           (cid == `SMCI_CMD_APPLY || cid == `SMCI_CMD_WRITE))) begin
        a_mode <= p_mode;
        a_ro <= p_ro;
        a_gt <= p_gt;
        a_cc <= p_cc;
        a_ct <= p_ct;
        a_bd <= p_bd;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/smci_top_props.sv
// assertion checker for the serial mode command interpreter ports
`timescale 1ns/1ns
`default_nettype none
module smci_top_props #(
  parameter TICK_CYCLES = 10000
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // host side
  input wire logic break_i,
  input wire logic spi_mode_i,
  input wire logic rx_ready_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  // radio side
  input wire logic [7:0] rf_data_o,
  input wire logic rf_valid_o,
  input wire logic rf_last_o,
  input wire logic rf_ready_i,
  // status
  input wire logic cmd_mode_o,
  input wire logic [1:0] serial_mode_o,
  input wire logic [2:0] baud_rate_o,
  input wire logic nv_write_o,
  input wire logic idle_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [7:0] pkt_cnt;
  sequence s_rf_take;
    rf_valid_o && rf_ready_i;
  endsequence
  sequence s_rf_stall;
    rf_valid_o && !rf_ready_i;
  endsequence
  // bytes already taken in the packet now on the radio side
  always @(posedge ref_clk_i) begin
    if (reset_i || (rf_valid_o && rf_ready_i && rf_last_o)) begin
      pkt_cnt <= 8'h00;
    end else if (rf_valid_o && rf_ready_i) begin
      pkt_cnt <= pkt_cnt + 8'h01;
    end
  end
  a_reset_pass_mode: assert property ($fell(reset_i) && !break_i && !spi_mode_i |->
    serial_mode_o == 2'h0 && !cmd_mode_o && !tx_valid_o && baud_rate_o == 3'h3)
    else $error("wrong state after reset");
  a_break_entry: assert property ($fell(reset_i) && break_i |=> cmd_mode_o &&
    baud_rate_o == 3'h3 ##[0:8] tx_valid_o && tx_data_o == 8'h4f)
    else $error("break at reset did not enter command mode");
  a_tx_holds: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("host byte dropped");
  a_rf_holds: assert property (s_rf_stall |=> rf_valid_o && $stable(rf_data_o) &&
    $stable(rf_last_o)) else $error("radio byte dropped while busy");
  a_rf_read_gap: assert property (s_rf_take |=> !rf_valid_o)
    else $error("radio byte without read cycle");
  a_pkt_size_limit: assert property (s_rf_take |->
    (rf_last_o ? pkt_cnt < 8'h64 : pkt_cnt < 8'h63)) else $error("packet too long");
  a_flush_stalls_rx: assert property (rf_valid_o |-> !rx_ready_o)
    else $error("input taken during flush");
  a_nv_one_pulse: assert property (nv_write_o |-> cmd_mode_o ##1 !nv_write_o)
    else $error("store request not a single pulse");
  a_spi_framed: assert property (spi_mode_i |-> serial_mode_o != 2'h0)
    else $error("pass-through offered over spi");
  a_idle_quiet: assert property (idle_o |-> !cmd_mode_o && !rf_valid_o && !tx_valid_o)
    else $error("idle while busy");
endmodule
bind smci_top smci_top_props #(.TICK_CYCLES(TICK_CYCLES)) smci_top_props_i (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .break_i(break_i), .spi_mode_i(spi_mode_i),
  .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
  .tx_ready_i(tx_ready_i), .rf_data_o(rf_data_o), .rf_valid_o(rf_valid_o),
  .rf_last_o(rf_last_o), .rf_ready_i(rf_ready_i), .cmd_mode_o(cmd_mode_o),
  .serial_mode_o(serial_mode_o), .baud_rate_o(baud_rate_o), .nv_write_o(nv_write_o),
  .idle_o(idle_o));
`default_nettype wire

// File: verification/smci_host_model.sv
// host serial receiver model: takes device bytes, optionally every other cycle
`timescale 1ns/1ns
`default_nettype none
module smci_host_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // device serial output
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic slow_i,
  // bytes seen by the host
  output logic [7:0] got_data_o,
  output logic got_o
);
  logic phase;
  // a slow host leaves the device holding each byte for a cycle
  assign tx_ready_o = !slow_i || phase;
  always @(posedge ref_clk_i) begin
    phase <= reset_i ? 1'b0 : !phase;
    got_o <= !reset_i && tx_valid_i && tx_ready_o;
    if (tx_valid_i && tx_ready_o) begin
      got_data_o <= tx_data_i;
    end
  end
endmodule
`default_nettype wire

// File: verification/test_smci_top.sv
// self-checking bench for the serial mode command interpreter
`timescale 1ns/1ns
`default_nettype none
module test_smci_top;
  logic clk = 1'b0, rst = 1'b1, brk = 1'b1, spi = 1'b0, rxv = 1'b0, rrv = 1'b0;
  logic rdy = 1'b1, rslow = 1'b0, tgl = 1'b0, rf_ready, tx_ready, got, fv, idle;
  logic rx_ready_o, tx_valid_o, rf_valid_o, rf_last_o, rf_rx_ready_o, cmd_mode_o, nv_write_o;
  logic [7:0] rxd = 8'h00, tx_data_o, rf_data_o, gd, fd;
  logic [1:0] serial_mode_o;
  logic [2:0] baud_rate_o;
  integer fails = 0, cmp_count = 0, nv = 0, n = 0, k;
  logic [7:0] hq[$], rq[$];
  integer lq[$];
  assign rf_ready = rdy && (!rslow || tgl);
  initial forever #50 clk = !clk;
  smci_top #(.TICK_CYCLES(10)) smci_top_i (.ref_clk_i(clk), .reset_i(rst), .rx_data_i(rxd),
    .rx_valid_i(rxv), .rx_ready_o(rx_ready_o), .break_i(brk), .spi_mode_i(spi),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready),
    .rf_data_o(rf_data_o), .rf_valid_o(rf_valid_o), .rf_last_o(rf_last_o),
    .rf_ready_i(rf_ready), .rf_rx_data_i(8'h5a), .rf_rx_valid_i(rrv),
    .rf_rx_ready_o(rf_rx_ready_o), .frame_data_o(fd), .frame_valid_o(fv), .frame_ready_i(1'b1),
    .cmd_mode_o(cmd_mode_o), .serial_mode_o(serial_mode_o), .baud_rate_o(baud_rate_o),
    .nv_write_o(nv_write_o), .idle_o(idle));
  smci_host_model smci_host_model_i (.ref_clk_i(clk), .reset_i(rst), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready), .slow_i(1'b1), .got_data_o(gd), .got_o(got));
  always @(posedge clk) begin
    tgl <= !tgl;
    if (got === 1'b1) hq.push_back(gd);
    if (nv_write_o === 1'b1) nv = nv + 1;
    if (rf_valid_o === 1'b1 && rf_ready) begin
      rq.push_back(rf_data_o);
      n = n + 1;
      if (rf_last_o === 1'b1) begin
        lq.push_back(n);
        n = 0;
      end
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  task wait_cyc(input integer c);
    begin
      repeat (c) @(posedge clk);
      #10;
    end
  endtask
  task bounded(input integer i, input integer lim);
    begin
      wait_cyc(1);
      if (i > lim) begin
        fails = fails + 1;
        finish_test;
      end
    end
  endtask
  // the byte is held until an edge at which the device is ready
  task send(input logic [7:0] b);
    integer i;
    begin
      rxd = b;
      rxv = 1'b1;
      for (i = 0; rx_ready_o !== 1'b1; i++) bounded(i, 5000);
      wait_cyc(1);
    end
  endtask
  task send_str(input string s);
    begin
      foreach (s[i]) send(s[i]);
      rxv = 1'b0;
    end
  endtask
  task expect_host(input string s);
    integer i;
    begin
      for (i = 0; hq.size() < s.len(); i++) bounded(i, 20000);
      foreach (s[j]) check(hq.pop_front(), s[j]);
    end
  endtask
  task cmd(input string s, input string r);
    begin
      send_str(s);
      expect_host(r);
    end
  endtask
  task expect_pkt(input integer len, input integer lim);
    integer i;
    begin
      for (i = 0; lq.size() == 0; i++) bounded(i, lim);
      check(lq.pop_front(), len);
    end
  endtask
  task rf_bytes(input string s);
    begin
      check(rq.size(), s.len());
      foreach (s[i]) if (rq.size() > 0) check(rq.pop_front(), s[i]);
    end
  endtask
  initial begin
    wait_cyc(6);
    rst = 1'b0;
    wait_cyc(1);
    brk = 1'b0;
    expect_host("OK\r");
    check(cmd_mode_o, 1'b1);
    check(idle, 1'b0);
    check(baud_rate_o, 3'h3);
    cmd("ATGT\r", "03E8\r");
    cmd("ATGT5,RO0x2\r", "OK\rOK\r");
    cmd("ATGT\r", "0005\r");
    cmd("ATRE,GT\r", "OK\r03E8\r");
    cmd("ATZZ\r", "ERROR\r");
    cmd("ATAP3\r", "ERROR\r");
    cmd("ATGT5,RO2,BD5\r", "OK\rOK\rOK\r");
    check(baud_rate_o, 3'h3);
    cmd("ATWR\r", "OK\r");
    check(nv, 1);
    cmd("ATCN\r", "OK\r");
    wait_cyc(5);
    check(cmd_mode_o, 1'b0);
    check(baud_rate_o, 3'h5);
    check(serial_mode_o, 2'h0);
    send_str("ab");
    expect_pkt(2, 100);
    rf_bytes("ab");
    rrv = 1'b1;
    for (k = 0; rf_rx_ready_o !== 1'b1; k++) bounded(k, 100);
    wait_cyc(1);
    rrv = 1'b0;
    expect_host("Z");
    // radio busy: bytes must wait in the buffer, then leave at half rate
    rdy = 1'b0;
    send_str("xyz");
    wait_cyc(60);
    check(rq.size(), 0);
    rslow = 1'b1;
    rdy = 1'b1;
    expect_pkt(3, 100);
    rf_bytes("xyz");
    rslow = 1'b0;
    for (k = 0; k < 101; k++) send(8'h30 + k[3:0]);
    rxv = 1'b0;
    expect_pkt(100, 400);
    expect_pkt(1, 400);
    check(rq[99], 8'h33);
    rq.delete();
    rdy = 1'b0;
    send_str("k");
    wait_cyc(60);
    send_str("+++");
    wait_cyc(60);
    rdy = 1'b1;
    expect_host("OK\r");
    check(cmd_mode_o, 1'b1);
    expect_pkt(1, 100);
    rf_bytes("k");
    cmd("ATRO0,CT14,AC\r", "OK\rOK\rOK\r");
    check(rq.size(), 0);
    for (k = 0; cmd_mode_o !== 1'b0; k++) bounded(k, 400);
    send_str("q");
    expect_pkt(1, 10);
    rf_bytes("q");
    spi = 1'b1;
    wait_cyc(2);
    check(serial_mode_o, 2'h2);
    send_str("f");
    check(fv, 1'b1);
    check(fd, 8'h66);
    check(rq.size(), 0);
    // second reset in mid-run, no break: plain pass-through at defaults
    spi = 1'b0;
    rst = 1'b1;
    wait_cyc(2);
    rst = 1'b0;
    wait_cyc(2);
    check(cmd_mode_o, 1'b0);
    check(serial_mode_o, 2'h0);
    check(baud_rate_o, 3'h3);
    check(idle, 1'b1);
    finish_test;
  end
endmodule
`default_nettype wire
